/* File: rtl/fssc_ctrl.sv */
// Mode controller: fail-safe entry and exit, reset pulse sequencing.
// Assumes pin and analog monitor inputs are asynchronous; SPI, watchdog
// and interrupt inputs come from logic on sys_clk.
`timescale 1ns/1ns
`include "fssc_regs.svh"
module fssc_ctrl #(
  parameter int unsigned CLHI_CYC = `FSSC_T_CLHI_MS * `FSSC_CLK_KHZ,
  parameter int unsigned TMO_CYC = `FSSC_T_TMO_MS * `FSSC_CLK_KHZ,
  parameter int unsigned LONG_RST_CYC =
    `FSSC_T_LONG_RST_MS * `FSSC_CLK_KHZ,
  parameter int unsigned SHORT_RST_CYC =
    `FSSC_T_SHORT_RST_MS * `FSSC_CLK_KHZ,
  parameter int unsigned HOLD_CYC = `FSSC_T_HOLD_MS * `FSSC_CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic oscSlow,
  input wire logic hostResetLineNIn,
  input wire logic mcuSupplyUv,
  input wire logic canWake,
  input wire logic linWake,
  input wire logic localWakeN,
  input wire logic wakeSwitchSupplyFault,
  input wire logic supplyCurrentHigh,
  input wire logic wakeSwitchSupplyOn,
  input wire logic wdgTimeout,
  input wire logic wdgOff,
  input wire logic modeWrStb,
  input wire logic [2:0] modeCode,
  input wire logic spiCountErr,
  input wire logic swDevMode,
  input wire logic resetOption,
  input wire logic userPulseLong,
  input wire logic intPending,
  output fssc_pkg::fssc_mode_t modeState,
  output logic hostResetLineN,
  output logic mcuSupplyEn,
  output logic pulseLong,
  output fssc_pkg::fssc_src_t resetSource
);
  localparam int CW = `FSSC_TW;

  fssc_pkg::fssc_mode_t mode_q, mode_d;
  fssc_pkg::fssc_src_t src_q, src_d;
  logic hostResetLineN_q;
  logic mcuSupplyEn_q;
  logic pulseLong_q, pulseLong_d;
  logic enter;
  logic failNow;
  logic [`FSSC_NS-1:0] syncA_q, syncB_q, prev_q;
  logic [`FSSC_NT-1:0] tRun, tExp;
  logic [CW-1:0] tLim [`FSSC_NT];
  logic lineHi, lineFall, wakeFall, busAct, uv, released;
  logic wrBad, wrInitN, wrInitF;

  // Codes outside the defined set are a host fault
  function automatic logic badCode(input logic [2:0] c);
    return !(c == `FSSC_CODE_INIT_NORMAL || c == `FSSC_CODE_INIT_FLASH ||
             c == `FSSC_CODE_STANDBY || c == `FSSC_CODE_SLEEP ||
             c == `FSSC_CODE_NORMAL);
  endfunction

  // Two stages before use; edges compare the second stage with a third (prev_q)
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncA_q <= '0;
      syncB_q <= '0;
      prev_q <= '0;
    end else begin
      syncA_q <= {supplyCurrentHigh, wakeSwitchSupplyFault, localWakeN,
                  linWake, canWake, mcuSupplyUv, hostResetLineNIn,
                  oscSlow};
      syncB_q <= syncA_q;
      prev_q <= syncB_q;
    end
  end

  assign lineHi = syncB_q[`FSSC_S_LINE];
  assign lineFall = prev_q[`FSSC_S_LINE] && !syncB_q[`FSSC_S_LINE];
  assign wakeFall = prev_q[`FSSC_S_WAKE] && !syncB_q[`FSSC_S_WAKE];
  assign busAct = syncB_q[`FSSC_S_CAN] || syncB_q[`FSSC_S_LIN];
  assign uv = syncB_q[`FSSC_S_UV];
  assign released = hostResetLineN_q;
  assign wrBad = modeWrStb && badCode(modeCode);
  assign wrInitN = modeWrStb && modeCode == `FSSC_CODE_INIT_NORMAL;
  assign wrInitF = modeWrStb && modeCode == `FSSC_CODE_INIT_FLASH;

  // Timer run conditions and limits
  always_comb begin
    tRun = '0;
    tRun[`FSSC_TM_PULSE] = !released &&
      (mode_q == fssc_pkg::STARTUP || mode_q == fssc_pkg::RESTART);
    tRun[`FSSC_TM_CLHI] = !released && lineHi &&
      (mode_q == fssc_pkg::STARTUP || mode_q == fssc_pkg::STANDBY ||
       mode_q == fssc_pkg::SLEEP);
    tRun[`FSSC_TM_CLLO] = released && !lineHi &&
      (mode_q == fssc_pkg::STARTUP || mode_q == fssc_pkg::RESTART);
    tRun[`FSSC_TM_INIT] = released && lineHi &&
      (mode_q == fssc_pkg::STARTUP || mode_q == fssc_pkg::RESTART);
    tRun[`FSSC_TM_UV] = uv && mode_q == fssc_pkg::STARTUP;
    tRun[`FSSC_TM_HOLD] = mode_q == fssc_pkg::STARTUP &&
      ((src_q == fssc_pkg::SRC_EXT && !lineHi) ||
       (src_q == fssc_pkg::SRC_UV && uv));
    tRun[`FSSC_TM_INT] = intPending &&
      (mode_q == fssc_pkg::NORMAL || mode_q == fssc_pkg::STANDBY ||
       mode_q == fssc_pkg::FLASH);
    tLim[`FSSC_TM_PULSE] = pulseLong_q ? CW'(LONG_RST_CYC) :
      CW'(SHORT_RST_CYC);
    tLim[`FSSC_TM_CLHI] = CW'(CLHI_CYC);
    tLim[`FSSC_TM_CLLO] = CW'(TMO_CYC);
    tLim[`FSSC_TM_INIT] = CW'(TMO_CYC);
    tLim[`FSSC_TM_UV] = CW'(TMO_CYC);
    tLim[`FSSC_TM_HOLD] = CW'(HOLD_CYC);
    tLim[`FSSC_TM_INT] = CW'(TMO_CYC);
  end

  fssc_tmr_if tb [`FSSC_NT] ();

  generate
    for (genvar g = 0; g < `FSSC_NT; g++) begin : gTmr
      assign tb[g].run = tRun[g];
      // Start-up re-entry keeps the hold and supply-low counts running
      assign tb[g].clear = enter && (mode_d != mode_q);
      assign tb[g].limit = tLim[g];
      assign tExp[g] = tb[g].expired;
      fssc_timer uTmr (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(tb[g])
      );
    end
  endgenerate

  // Fail-safe causes, outranking every other transition
  always_comb begin
    failNow = 1'b0;
    // RULE1: oscillator too slow
    if (syncB_q[`FSSC_S_OSC] && mode_q != fssc_pkg::FAILSAFE) begin
      failNow = 1'b1;
    end
    // RULE2: line clamped high
    if (tExp[`FSSC_TM_CLHI]) begin
      failNow = 1'b1;
    end
    // RULE3: line clamped low
    if (tExp[`FSSC_TM_CLLO]) begin
      failNow = 1'b1;
    end
    // RULE16: long external hold
    // RULE17: long undervoltage
    if (tExp[`FSSC_TM_HOLD]) begin
      failNow = 1'b1;
    end
    // RULE7: supply low too long
    if (tExp[`FSSC_TM_UV]) begin
      failNow = 1'b1;
    end
    if (mode_q == fssc_pkg::RESTART) begin
      // RULE4: edge during init
      if (released && lineFall) begin
        failNow = 1'b1;
      end
      // RULE5: init timeout, unless development
      if (tExp[`FSSC_TM_INIT] && !swDevMode) begin
        failNow = 1'b1;
      end
      // RULE6: bad code or frame length
      if (spiCountErr || (modeWrStb && !wrInitN)) begin
        failNow = 1'b1;
      end
      // RULE8: supply low after release
      if (released && uv) begin
        failNow = 1'b1;
      end
    end
  end

  // Next mode
  always_comb begin
    logic toUser;
    logic toLong;
    logic toRestart;
    fssc_pkg::fssc_src_t why;
    toUser = 1'b0;
    toLong = 1'b0;
    toRestart = 1'b0;
    why = src_q;
    mode_d = mode_q;
    enter = 1'b0;
    src_d = src_q;
    pulseLong_d = pulseLong_q;
    // RULE22: fail-safe first
    if (failNow) begin
      mode_d = fssc_pkg::FAILSAFE;
      enter = 1'b1;
      src_d = fssc_pkg::SRC_FAIL;
    end else begin
      unique case (mode_q)
        fssc_pkg::FAILSAFE: begin
          // RULE9: wake with running oscillator
          if (!syncB_q[`FSSC_S_OSC] && (busAct || wakeFall)) begin
            toLong = 1'b1;
            why = fssc_pkg::SRC_WAKE;
          end
        end
        fssc_pkg::STARTUP: begin
          // RULE13: undervoltage restarts the pulse
          if (uv && released && lineHi) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_UV;
          end else if (released) begin
            // RULE14: host init selects the mode
            if (wrInitN) begin
              mode_d = fssc_pkg::NORMAL;
              enter = 1'b1;
            end else if (wrInitF) begin
              mode_d = fssc_pkg::FLASH;
              enter = 1'b1;
            end else if (modeWrStb || spiCountErr || lineFall ||
                         tExp[`FSSC_TM_INIT]) begin
              toRestart = 1'b1;
            end
          end
        end
        fssc_pkg::RESTART: begin
          // RULE12: external edges ignored here
          // RULE13: undervoltage ignored here
          if (released && wrInitN) begin
            mode_d = fssc_pkg::NORMAL;
            enter = 1'b1;
          end
        end
        fssc_pkg::NORMAL, fssc_pkg::FLASH: begin
          // RULE12: external reset edge
          if (lineFall) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_EXT;
          // RULE13: undervoltage while active
          end else if (uv) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_UV;
          // RULE20: unserved interrupt
          end else if (tExp[`FSSC_TM_INT]) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_INT;
          end else if (wdgTimeout) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_WDG;
          end else if (modeWrStb) begin
            if (mode_q == fssc_pkg::NORMAL &&
                modeCode == `FSSC_CODE_STANDBY) begin
              mode_d = fssc_pkg::STANDBY;
              enter = 1'b1;
            end else if (mode_q == fssc_pkg::NORMAL &&
                         modeCode == `FSSC_CODE_SLEEP) begin
              mode_d = fssc_pkg::SLEEP;
              enter = 1'b1;
            end else if (modeCode != `FSSC_CODE_NORMAL) begin
              toUser = 1'b1;
              why = fssc_pkg::SRC_MODE;
            end
          end
        end
        fssc_pkg::STANDBY: begin
          // RULE12: external reset edge
          if (lineFall) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_EXT;
          // RULE20: unserved interrupt
          end else if (tExp[`FSSC_TM_INT]) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_INT;
          // RULE19: wake events win over a sleep request
          end else if (resetOption && (busAct || wakeFall)) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_WAKE;
          end else if (resetOption && (wdgTimeout ||
                       (wdgOff && syncB_q[`FSSC_S_CUR]))) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_WDG;
          // RULE18: bad mode code
          end else if (wrBad) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_MODE;
          end else if (modeWrStb &&
                       modeCode == `FSSC_CODE_NORMAL) begin
            mode_d = fssc_pkg::NORMAL;
            enter = 1'b1;
          end else if (modeWrStb && modeCode == `FSSC_CODE_SLEEP) begin
            mode_d = fssc_pkg::SLEEP;
            enter = 1'b1;
          end
        end
        fssc_pkg::SLEEP: begin
          // RULE15: wake sources
          if (busAct || wakeFall || wdgTimeout ||
              (wakeSwitchSupplyOn && syncB_q[`FSSC_S_WSF])) begin
            toUser = 1'b1;
            why = fssc_pkg::SRC_WAKE;
          end
        end
        default: begin
          mode_d = fssc_pkg::FAILSAFE;
          enter = 1'b1;
        end
      endcase
      if (toUser || toLong) begin
        mode_d = fssc_pkg::STARTUP;
        enter = 1'b1;
        src_d = why;
        // RULE10: long pulse on fail-safe exit
        pulseLong_d = toLong ? 1'b1 : userPulseLong;
      end else if (toRestart) begin
        mode_d = fssc_pkg::RESTART;
        enter = 1'b1;
        src_d = fssc_pkg::SRC_MODE;
        // RULE21: restart always long
        pulseLong_d = 1'b1;
      end
    end
  end

  // RULE11: power-on enters start-up, long pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= fssc_pkg::STARTUP;
      src_q <= fssc_pkg::SRC_POR;
      pulseLong_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      src_q <= src_d;
      pulseLong_q <= pulseLong_d;
    end
  end

  // Line low on every entry that resets the host; released at pulse end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hostResetLineN_q <= 1'b0;
    end else if (enter) begin
      hostResetLineN_q <= !(mode_d == fssc_pkg::STARTUP ||
        mode_d == fssc_pkg::RESTART || mode_d == fssc_pkg::SLEEP ||
        mode_d == fssc_pkg::FAILSAFE);
    end else if (tExp[`FSSC_TM_PULSE]) begin
      hostResetLineN_q <= 1'b1;
    end
  end

  // RULE10: supply back on when leaving fail-safe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mcuSupplyEn_q <= 1'b1;
    end else if (enter) begin
      mcuSupplyEn_q <= !(mode_d == fssc_pkg::FAILSAFE ||
        mode_d == fssc_pkg::SLEEP);
    end
  end

  assign modeState = mode_q;
  assign hostResetLineN = hostResetLineN_q;
  assign mcuSupplyEn = mcuSupplyEn_q;
  assign pulseLong = pulseLong_q;
  assign resetSource = src_q;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_restartEntry;
    mode_q != fssc_pkg::RESTART ##1 mode_q == fssc_pkg::RESTART;
  endsequence

  sequence s_wakeExit;
    mode_q == fssc_pkg::FAILSAFE && !syncB_q[`FSSC_S_OSC] &&
      (busAct || wakeFall);
  endsequence

  property p_oscFail;
    syncB_q[`FSSC_S_OSC] |=> mode_q == fssc_pkg::FAILSAFE;
  endproperty
  a_oscFail: assert property (p_oscFail) // RULE1
    else $error("slow oscillator did not force fail-safe");

  property p_clampHigh;
    tExp[`FSSC_TM_CLHI] |=> mode_q == fssc_pkg::FAILSAFE;
  endproperty
  a_clampHigh: assert property (p_clampHigh) // RULE2
    else $error("clamped high line did not force fail-safe");

  property p_clampLow;
    tExp[`FSSC_TM_CLLO] |=> mode_q == fssc_pkg::FAILSAFE &&
      !hostResetLineN_q;
  endproperty
  a_clampLow: assert property (p_clampLow) // RULE3
    else $error("clamped low line did not force fail-safe");

  property p_initTmo;
    mode_q == fssc_pkg::RESTART && tExp[`FSSC_TM_INIT] && !swDevMode
      |=> mode_q == fssc_pkg::FAILSAFE;
  endproperty
  a_initTmo: assert property (p_initTmo) // RULE5
    else $error("restart init timeout missed");

  property p_spiErr;
    mode_q == fssc_pkg::RESTART && spiCountErr
      |=> mode_q == fssc_pkg::FAILSAFE;
  endproperty
  a_spiErr: assert property (p_spiErr) // RULE6
    else $error("restart SPI count error missed");

  property p_wakeExit;
    s_wakeExit |=> mode_q == fssc_pkg::STARTUP && pulseLong_q &&
      mcuSupplyEn_q && !hostResetLineN_q;
  endproperty
  a_wakeExit: assert property (p_wakeExit) // RULE10
    else $error("fail-safe exit did not restart with long pulse");

  property p_restartLong;
    s_restartEntry |-> pulseLong_q && !hostResetLineN_q;
  endproperty
  a_restartLong: assert property (p_restartLong) // RULE21
    else $error("restart entered without long pulse");

  property p_extEdge;
    mode_q == fssc_pkg::NORMAL && lineFall && !failNow
      |=> mode_q == fssc_pkg::STARTUP && src_q == fssc_pkg::SRC_EXT &&
      pulseLong_q == $past(userPulseLong);
  endproperty
  a_extEdge: assert property (p_extEdge) // RULE12
    else $error("external reset edge not handled");

  property p_intTmo;
    tExp[`FSSC_TM_INT] && !failNow |=> mode_q == fssc_pkg::STARTUP;
  endproperty
  a_intTmo: assert property (p_intTmo) // RULE20
    else $error("unserved interrupt did not reset");

  property p_sleepWake;
    mode_q == fssc_pkg::SLEEP && wdgTimeout && !failNow
      |=> mode_q == fssc_pkg::STARTUP && mcuSupplyEn_q;
  endproperty
  a_sleepWake: assert property (p_sleepWake) // RULE15
    else $error("sleep did not wake on watchdog");
endmodule

/* File: rtl/fssc_pkg.sv */
// Types of the fail-safe system controller.
// Assumes nothing of its surroundings.
package fssc_pkg;
  typedef enum logic [2:0] {
    FAILSAFE = 3'h0,
    STARTUP = 3'h1,
    RESTART = 3'h2,
    NORMAL = 3'h3,
    STANDBY = 3'h4,
    SLEEP = 3'h5,
    FLASH = 3'h6
  } fssc_mode_t;
  typedef enum logic [2:0] {
    SRC_POR = 3'h0,
    SRC_EXT = 3'h1,
    SRC_UV = 3'h2,
    SRC_WDG = 3'h3,
    SRC_WAKE = 3'h4,
    SRC_INT = 3'h5,
    SRC_MODE = 3'h6,
    SRC_FAIL = 3'h7
  } fssc_src_t;
endpackage

/* File: rtl/fssc_regs.svh */
// Constants of the fail-safe system controller: times, codes, indices.
// Assumes a single 10 MHz oscillator clock for all logic.
//
// Contract
// RULE1: Slow oscillator forces fail-safe at once.
// RULE2: Reset line stuck high 128 ms: fail-safe.
// RULE3: Reset line low 256 ms after release.
// RULE4: Reset falling edge in restart init: fail-safe.
// RULE5: Restart init not done in 256 ms.
// RULE6: Restart bad code or SPI count: fail-safe.
// RULE7: Start-up supply low 256 ms: fail-safe.
// RULE8: Restart supply low after release: fail-safe.
// RULE9: Fail-safe exit on bus or wake edge.
// RULE10: Fail-safe exit: start-up, supply on, long pulse.
// RULE11: Power-on: start-up with long pulse.
// RULE12: External reset edge: start-up, user length.
// RULE13: Supply undervoltage: start-up, user length.
// RULE14: Host init write selects normal or flash.
// RULE15: Sleep wakes to start-up on events.
// RULE16: Long external reset hold: fail-safe.
// RULE17: Long undervoltage after reset: fail-safe.
// RULE18: Standby bad code: start-up.
// RULE19: Standby reset option wake events: start-up.
// RULE20: Interrupt unserved 256 ms: start-up.
// RULE21: Restart entry always uses long pulse.
// RULE22: Mode register; fail-safe has top priority.
`ifndef FSSC_REGS_SVH
`define FSSC_REGS_SVH

`define FSSC_CLK_KHZ 10000
`define FSSC_T_CLHI_MS 128
`define FSSC_T_TMO_MS 256
`define FSSC_T_LONG_RST_MS 20
`define FSSC_T_SHORT_RST_MS 2
`define FSSC_T_HOLD_MS 512
`define FSSC_TW 23
`define FSSC_NT 7
`define FSSC_TM_PULSE 0
`define FSSC_TM_CLHI 1
`define FSSC_TM_CLLO 2
`define FSSC_TM_INIT 3
`define FSSC_TM_UV 4
`define FSSC_TM_HOLD 5
`define FSSC_TM_INT 6
`define FSSC_NS 8
`define FSSC_S_OSC 0
`define FSSC_S_LINE 1
`define FSSC_S_UV 2
`define FSSC_S_CAN 3
`define FSSC_S_LIN 4
`define FSSC_S_WAKE 5
`define FSSC_S_WSF 6
`define FSSC_S_CUR 7
`define FSSC_CODE_INIT_NORMAL 3'h1
`define FSSC_CODE_INIT_FLASH 3'h2
`define FSSC_CODE_STANDBY 3'h3
`define FSSC_CODE_SLEEP 3'h4
`define FSSC_CODE_NORMAL 3'h5

`endif

/* File: rtl/fssc_timer.sv */
// Interval timer: counts while run holds, flags when limit is reached.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/1ns
`include "fssc_regs.svh"
module fssc_timer (
  input wire logic sys_clk,
  input wire logic rst,
  fssc_tmr_if.tmr bus
);
  logic [`FSSC_TW-1:0] cnt_q;

  // Saturates so the flag holds until run drops
  always_ff @(posedge sys_clk) begin
    if (rst || bus.clear || !bus.run) begin
      cnt_q <= '0;
    end else if (cnt_q != bus.limit) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign bus.expired = bus.run && (cnt_q == bus.limit);
endmodule

/* File: rtl/fssc_tmr_if.sv */
// Link between the mode controller and one of its interval timers.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`include "fssc_regs.svh"
interface fssc_tmr_if;
  logic run;
  logic clear;
  logic [`FSSC_TW-1:0] limit;
  logic expired;
  modport ctrl (output run, output clear, output limit, input expired);
  modport tmr (input run, input clear, input limit, output expired);
endinterface

/* File: sim/fssc_ctrl_tb.sv */
// Self-checking bench of the mode controller with a host model.
// Assumes small timer parameters so long counts stay short.
`timescale 1ns/1ns
`include "fssc_regs.svh"
module fssc_ctrl_tb;
  localparam int unsigned LONG = 20;
  localparam int unsigned CLHI = 10;
  localparam int unsigned TMO = 60;
  localparam int unsigned HOLD = 40;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic oscSlow = 1'b0, mcuSupplyUv = 1'b0, canWake = 1'b0, linWake = 1'b0;
  logic localWakeN = 1'b1, wsFault = 1'b0, curHigh = 1'b0, wsOn = 1'b0;
  logic wdgTimeout = 1'b0, wdgOff = 1'b0, swDevMode = 1'b0;
  logic resetOption = 1'b0, userPulseLong = 1'b0, intPending = 1'b0;
  logic clampLow = 1'b0, clampHigh = 1'b0;
  logic lineLevel, modeWrStb, spiCountErr, hostResetLineN, mcuSupplyEn;
  logic pulseLong;
  logic [2:0] modeCode;
  fssc_pkg::fssc_mode_t modeState;
  fssc_pkg::fssc_src_t resetSource;
  int failures = 0;
  int checks = 0;

  always #50 sys_clk = ~sys_clk;

  fssc_host_model host_u (.sys_clk(sys_clk), .hostResetLineN(hostResetLineN),
    .clampLow(clampLow), .clampHigh(clampHigh), .lineLevel(lineLevel),
    .modeWrStb(modeWrStb), .modeCode(modeCode), .spiCountErr(spiCountErr));

  fssc_ctrl #(.CLHI_CYC(CLHI), .TMO_CYC(TMO), .LONG_RST_CYC(LONG),
    .SHORT_RST_CYC(5), .HOLD_CYC(HOLD)) dut_u (.sys_clk(sys_clk),
    .rst(rst), .oscSlow(oscSlow), .hostResetLineNIn(lineLevel),
    .mcuSupplyUv(mcuSupplyUv), .canWake(canWake), .linWake(linWake),
    .localWakeN(localWakeN), .wakeSwitchSupplyFault(wsFault),
    .supplyCurrentHigh(curHigh), .wakeSwitchSupplyOn(wsOn),
    .wdgTimeout(wdgTimeout), .wdgOff(wdgOff), .modeWrStb(modeWrStb),
    .modeCode(modeCode), .spiCountErr(spiCountErr), .swDevMode(swDevMode),
    .resetOption(resetOption), .userPulseLong(userPulseLong),
    .intPending(intPending), .modeState(modeState),
    .hostResetLineN(hostResetLineN), .mcuSupplyEn(mcuSupplyEn),
    .pulseLong(pulseLong), .resetSource(resetSource));

  task automatic conclude();
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic checkMode(input fssc_pkg::fssc_mode_t a,
    input fssc_pkg::fssc_mode_t e);
    checks++;
    if (a !== e) begin
      failures++;
      $display("unexpected mode at %0t: got %h want %h", $time, a, e);
    end
  endtask

  task automatic checkSrc(input fssc_pkg::fssc_src_t a,
    input fssc_pkg::fssc_src_t e);
    checks++;
    if (a !== e) begin
      failures++;
      $display("unexpected source at %0t: got %h want %h", $time, a, e);
    end
  endtask

  task automatic checkBit(input logic a, input logic e);
    checks++;
    if (a !== e) begin
      failures++;
      $display("unexpected bit at %0t: got %h want %h", $time, a, e);
    end
  endtask

  // Samples at the falling edge, well clear of output updates
  task automatic waitMode(input fssc_pkg::fssc_mode_t m, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      if (modeState === m) break;
    end
    checkMode(modeState, m);
  endtask

  task automatic waitRelease(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      if (hostResetLineN === 1'b1) break;
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic doReset();
    @(posedge sys_clk);
    rst <= 1'b1;
    {oscSlow, mcuSupplyUv, canWake, linWake, wsFault, wsOn} <= 6'h00;
    {intPending, clampLow, clampHigh, wdgTimeout} <= 4'h0;
    localWakeN <= 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic bootNormal();
    doReset();
    waitRelease(LONG + 8);
    host_u.writeMode(`FSSC_CODE_INIT_NORMAL);
    waitMode(fssc_pkg::NORMAL, 4);
  endtask

  task automatic testPowerOn();
    doReset();
    @(negedge sys_clk);
    checkMode(modeState, fssc_pkg::STARTUP);
    checkSrc(resetSource, fssc_pkg::SRC_POR);
    checkBit(pulseLong, 1'b1);
    checkBit(mcuSupplyEn, 1'b1);
    repeat (LONG - 3) @(negedge sys_clk);
    checkBit(hostResetLineN, 1'b0);
    waitRelease(8);
    checkBit(hostResetLineN, 1'b1);
    clampLow <= 1'b1;
    waitMode(fssc_pkg::FAILSAFE, TMO + LONG + 12);
  endtask

  task automatic testClampHigh();
    doReset();
    @(posedge sys_clk);
    clampHigh <= 1'b1;
    repeat (CLHI - 4) @(negedge sys_clk);
    checkMode(modeState, fssc_pkg::STARTUP);
    waitMode(fssc_pkg::FAILSAFE, 10);
  endtask

  task automatic testExtReset();
    bootNormal();
    @(posedge sys_clk);
    clampLow <= 1'b1;
    waitMode(fssc_pkg::STARTUP, 8);
    checkSrc(resetSource, fssc_pkg::SRC_EXT);
    checkBit(pulseLong, 1'b0);
    waitMode(fssc_pkg::FAILSAFE, HOLD + 20);
  endtask

  task automatic testUv();
    bootNormal();
    @(posedge sys_clk);
    mcuSupplyUv <= 1'b1;
    waitMode(fssc_pkg::STARTUP, 6);
    checkSrc(resetSource, fssc_pkg::SRC_UV);
    checkBit(hostResetLineN, 1'b0);
    checkBit(pulseLong, 1'b0);
    waitMode(fssc_pkg::FAILSAFE, HOLD + 20);
  endtask

  task automatic testInt();
    bootNormal();
    @(posedge sys_clk);
    intPending <= 1'b1;
    repeat (TMO - 5) @(negedge sys_clk);
    checkMode(modeState, fssc_pkg::NORMAL);
    waitMode(fssc_pkg::STARTUP, 12);
    checkSrc(resetSource, fssc_pkg::SRC_INT);
  endtask

  task automatic testOsc();
    bootNormal();
    @(posedge sys_clk);
    oscSlow <= 1'b1;
    waitMode(fssc_pkg::FAILSAFE, 5);
    checkBit(mcuSupplyEn, 1'b0);
    @(posedge sys_clk);
    canWake <= 1'b1;
    repeat (8) @(negedge sys_clk);
    checkMode(modeState, fssc_pkg::FAILSAFE);
    @(posedge sys_clk);
    oscSlow <= 1'b0;
    waitMode(fssc_pkg::STARTUP, 8);
    checkBit(pulseLong, 1'b1);
    checkBit(mcuSupplyEn, 1'b1);
    checkSrc(resetSource, fssc_pkg::SRC_WAKE);
  endtask

  task automatic testRestart();
    bootNormal();
    @(posedge sys_clk);
    mcuSupplyUv <= 1'b1;
    waitMode(fssc_pkg::STARTUP, 6);
    @(posedge sys_clk);
    mcuSupplyUv <= 1'b0;
    waitRelease(20);
    host_u.writeMode(3'h7);
    waitMode(fssc_pkg::RESTART, 4);
    checkBit(pulseLong, 1'b1);
    waitRelease(LONG + 8);
    host_u.badFrame();
    waitMode(fssc_pkg::FAILSAFE, 4);
  endtask

  // Events 0..4 wake from sleep; 5 bad code, 6..7 reset option in standby
  task automatic testWake(input int k);
    fssc_pkg::fssc_src_t expSrc;
    expSrc = (k == 7) ? fssc_pkg::SRC_WDG :
      (k == 5) ? fssc_pkg::SRC_MODE : fssc_pkg::SRC_WAKE;
    bootNormal();
    host_u.writeMode(`FSSC_CODE_STANDBY);
    waitMode(fssc_pkg::STANDBY, 4);
    if (k < 5) begin
      host_u.writeMode(`FSSC_CODE_SLEEP);
      waitMode(fssc_pkg::SLEEP, 4);
      checkBit(mcuSupplyEn, 1'b0);
    end
    @(posedge sys_clk);
    userPulseLong <= k >= 5;
    case (k)
      0: canWake <= 1'b1;
      1: linWake <= 1'b1;
      2: localWakeN <= 1'b0;
      3: wdgTimeout <= 1'b1;
      4: {wsOn, wsFault} <= 2'h3;
      5: host_u.writeMode(3'h7);
      6: {resetOption, canWake} <= 2'h3;
      default: {resetOption, wdgOff, curHigh} <= 3'h7;
    endcase
    @(posedge sys_clk);
    wdgTimeout <= 1'b0;
    waitMode(fssc_pkg::STARTUP, 8);
    checkSrc(resetSource, expSrc);
    checkBit(pulseLong, k >= 5);
  endtask

  initial begin
    #2000000;
    failures++;
    conclude();
  end

  initial begin
    testPowerOn();
    testClampHigh();
    testExtReset();
    testUv();
    testInt();
    testOsc();
    testRestart();
    for (int k = 0; k < 8; k++) begin
      testWake(k);
    end
    conclude();
  end
endmodule

/* File: sim/fssc_host_model.sv */
// Host microcontroller model: senses the reset line and writes modes.
// Assumes the controller drives the line push-pull; the host may clamp it.
`timescale 1ns/1ns
`include "fssc_regs.svh"
module fssc_host_model (
  input wire logic sys_clk,
  input wire logic hostResetLineN,
  input wire logic clampLow,
  input wire logic clampHigh,
  output logic lineLevel,
  output logic modeWrStb,
  output logic [2:0] modeCode,
  output logic spiCountErr
);
  assign lineLevel = clampLow ? 1'b0 : (clampHigh ? 1'b1 : hostResetLineN);
  initial begin
    modeWrStb = 1'b0;
    modeCode = 3'h0;
    spiCountErr = 1'b0;
  end
  task automatic writeMode(input logic [2:0] code);
    @(posedge sys_clk);
    modeWrStb <= 1'b1;
    modeCode <= code;
    @(posedge sys_clk);
    modeWrStb <= 1'b0;
    // Stale code would hide a strobe-less capture
    modeCode <= ~code;
  endtask
  task automatic badFrame();
    @(posedge sys_clk);
    spiCountErr <= 1'b1;
    @(posedge sys_clk);
    spiCountErr <= 1'b0;
  endtask
endmodule
